// file: src/pdmc_defines.vh
`ifndef PDMC_DEFINES_VH
`define PDMC_DEFINES_VH
// ****************************************
// Register byte addresses
// ****************************************
`define PDMC_ADDR_STBY 12'h000
`define PDMC_ADDR_SYS1 12'h004
`define PDMC_ADDR_SYS2 12'h008
`define PDMC_ADDR_STAT 12'h00C
// ****************************************
// Field positions
// ****************************************
`define PDMC_BIT_SERIAL 5
`define PDMC_BIT_ADC 4
`define PDMC_BIT_WDOG 3
`define PDMC_BIT_TMR16 2
`define PDMC_BIT_TMR8 1
`define PDMC_STBY_MASK 8'h3E
`define PDMC_BIT_SSEL 7
`define PDMC_SWAIT_LSB 4
`define PDMC_SYS1_MASK 8'hF0
`define PDMC_BIT_SUBSLEEP_SELECT 7
`define PDMC_BIT_DIRECT_TRANSITION_SELECT 5
`define PDMC_DIV_LSB 2
`define PDMC_SYS2_MASK 8'hBC
// ****************************************
// Reset values
// ****************************************
`define PDMC_RST_REG 8'h00
// ****************************************
// Settling wait counts in states
// ****************************************
`define PDMC_WAIT_0 18'h02000
`define PDMC_WAIT_1 18'h04000
`define PDMC_WAIT_2 18'h08000
`define PDMC_WAIT_3 18'h10000
`define PDMC_WAIT_4 18'h20000
`define PDMC_WAIT_5 18'h00400
`define PDMC_WAIT_6 18'h00080
`define PDMC_WAIT_7 18'h00010
`endif

// file: src/pdmc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
module pdmc_top (
   input wire mclk,
   input wire arst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire sleep_req,
   input wire irq_pending,
   input wire irq_mask,
   input wire direct_irq_en,
   input wire ext_wake,
   input wire wdog_int_osc,
   input wire tmr16_int_clk,
   input wire subclk_tick,
   output reg cpu_halt,
   output reg cpu_reset,
   output reg irq_handle,
   output reg osc_run,
   output reg port_hiz,
   output reg port_hold,
   output reg freq_apply,
   output reg [2:0] active_clock_divider,
   output reg periph_div_en,
   output wire serial_clk_en,
   output wire adc_clk_en,
   output wire wdog_clk_en,
   output wire tmr16_clk_en,
   output wire tmr8_clk_en,
   output reg serial_rst,
   output reg adc_rst,
   output reg tmr8_rst
);
   // ****************************************
   // States
   // ****************************************
   localparam ST_ACT = 5'b00001;
   localparam ST_SLP = 5'b00010;
   localparam ST_SSL = 5'b00100;
   localparam ST_STB = 5'b01000;
   localparam ST_WAIT = 5'b10000;

   reg [7:0] peripheral_standby_control_q;
   reg [7:0] system_control_one_q;
   reg [7:0] system_control_two_q;
   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [17:0] wait_q;
   reg [17:0] wait_d;
   reg [4:0] gate_q;
   reg wake_ok;
   wire wr_en;
   wire stby_mode;
   wire ssl_mode;
   wire instr_take;
   wire subsleep_select_hit;
   wire [4:0] want_run;
   wire [2:0] settle_wait_select;
   wire standby_select;
   wire subsleep_select;
   wire direct_transition_select;

   // Settle count lookup, used at sleep entry
   function [17:0] settle_count;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: settle_count = `PDMC_WAIT_0;
            3'h1: settle_count = `PDMC_WAIT_1;
            3'h2: settle_count = `PDMC_WAIT_2;
            3'h3: settle_count = `PDMC_WAIT_3;
            3'h4: settle_count = `PDMC_WAIT_4;
            3'h5: settle_count = `PDMC_WAIT_5;
            3'h6: settle_count = `PDMC_WAIT_6;
            default: settle_count = `PDMC_WAIT_7;
         endcase
      end
   endfunction

   // Deep modes stop the system oscillator; several outputs share this decode
   function deep_mode;
      input [4:0] st;
      begin
         deep_mode = (st == ST_SSL) || (st == ST_STB);
      end
   endfunction

   assign settle_wait_select = system_control_one_q[`PDMC_SWAIT_LSB+2:`PDMC_SWAIT_LSB];
   assign standby_select = system_control_one_q[`PDMC_BIT_SSEL];
   assign subsleep_select = system_control_two_q[`PDMC_BIT_SUBSLEEP_SELECT];
   assign direct_transition_select = system_control_two_q[`PDMC_BIT_DIRECT_TRANSITION_SELECT];

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel & penable & pwrite;

   // masked writes
   // Reserved bits are cut by masks so they never hold a one
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         peripheral_standby_control_q <= `PDMC_RST_REG;
         system_control_one_q <= `PDMC_RST_REG;
         system_control_two_q <= `PDMC_RST_REG;
      end else if (wr_en) begin
         case (paddr)
            `PDMC_ADDR_STBY: begin
               peripheral_standby_control_q <= pwdata[7:0] & `PDMC_STBY_MASK;
            end
            `PDMC_ADDR_SYS1: begin
               system_control_one_q <= pwdata[7:0] & `PDMC_SYS1_MASK;
            end
            `PDMC_ADDR_SYS2: begin
               system_control_two_q <= pwdata[7:0] & `PDMC_SYS2_MASK;
            end
            default: begin
               system_control_two_q <= system_control_two_q;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (paddr)
         `PDMC_ADDR_STBY: prdata = {24'h000000, peripheral_standby_control_q};
         `PDMC_ADDR_SYS1: prdata = {24'h000000, system_control_one_q};
         `PDMC_ADDR_SYS2: prdata = {24'h000000, system_control_two_q};
         `PDMC_ADDR_STAT: prdata = {27'h0000000, state_q};
         default: prdata = 32'h00000000;
      endcase
   end

   // ****************************************
   // Mode sequencer
   // ****************************************
   // wake qualification
   // wake inputs are never gated by mode
   always @* begin
      wake_ok = (irq_pending | ext_wake) & ~irq_mask;
   end

   always @* begin
      state_d = state_q;
      wait_d = wait_q;
      case (state_q)
         ST_ACT: begin
            if (sleep_req) begin
               if (direct_transition_select & ~subsleep_select) begin
                  if (!direct_irq_en) begin
                     state_d = ST_SLP;
                  end
               end else if (standby_select) begin
                  state_d = ST_STB;
               end else if (subsleep_select) begin
                  state_d = ST_SSL;
               end else begin
                  state_d = ST_SLP;
               end
               wait_d = settle_count(settle_wait_select);
            end
         end
         ST_SLP: begin
            if (wake_ok) begin
               state_d = ST_ACT;
            end
         end
         ST_SSL, ST_STB: begin
            if (wake_ok) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wait_q <= 18'h00001) begin
               state_d = ST_ACT;
            end else begin
               wait_d = wait_q - 18'h00001;
            end
         end
         default: begin
            state_d = ST_ACT;
         end
      endcase
   end

   // reset pin forces active
   // The bench holds arst_n low until the oscillator is stable
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_ACT;
         wait_q <= 18'h00000;
      end else begin
         state_q <= state_d;
         wait_q <= wait_d;
      end
   end

   // ****************************************
   // Mode outputs, registered
   // ****************************************
   // Decodes shared by the output groups below
   assign stby_mode = (state_q == ST_STB);
   assign ssl_mode = (state_q == ST_SSL);
   // A sleep instruction only counts while the core runs
   assign instr_take = (state_q == ST_ACT) & sleep_req;
   assign subsleep_select_hit = instr_take & subsleep_select;

   // CPU side: reset, halt and exception strobes
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_halt <= 1'b0;
         cpu_reset <= 1'b1;
         irq_handle <= 1'b0;
         freq_apply <= 1'b0;
         active_clock_divider <= 3'h0;
      end else begin
         // reset state ends at the first edge after release
         cpu_reset <= 1'b0;
         cpu_halt <= (state_d != ST_ACT);
         irq_handle <= (state_d == ST_ACT) && (state_q != ST_ACT);
         // divider applies after any sleep instruction
         freq_apply <= instr_take;
         if (instr_take) begin
            active_clock_divider <= system_control_two_q[`PDMC_DIV_LSB+2:`PDMC_DIV_LSB];
         end
      end
   end

   // Oscillator and port side
   // Driven from the next state so pins change with the mode, not a cycle later
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_run <= 1'b1;
         port_hiz <= 1'b0;
         port_hold <= 1'b0;
         periph_div_en <= 1'b1;
      end else begin
         osc_run <= ~deep_mode(state_d);
         port_hiz <= (state_d == ST_STB);
         port_hold <= (state_d == ST_SSL);
         periph_div_en <= (state_d == ST_ACT) || (state_d == ST_SLP);
      end
   end

   // Module resets
   // The pulse on the instruction cycle itself adds nothing: a subsleep selection
   // always ends in standby or subsleep, which already hold the modules in reset
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         serial_rst <= 1'b0;
         adc_rst <= 1'b0;
         tmr8_rst <= 1'b0;
      end else begin
         serial_rst <= deep_mode(state_d) || subsleep_select_hit;
         adc_rst <= deep_mode(state_d) || subsleep_select_hit;
         tmr8_rst <= deep_mode(state_d) || subsleep_select_hit;
      end
   end

   // ****************************************
   // Clock gating enables
   // ****************************************
   // standby bits stop clocks
   // watchdog on internal oscillator ignores standby
   // sixteen-bit timer counts on subclock in standby
   assign want_run[4] = ~peripheral_standby_control_q[`PDMC_BIT_SERIAL] & periph_div_en;
   assign want_run[3] = ~peripheral_standby_control_q[`PDMC_BIT_ADC] & periph_div_en;
   // subsleep freezes the watchdog even on its own oscillator
   assign want_run[2] = (wdog_int_osc & ~ssl_mode) |
      (~peripheral_standby_control_q[`PDMC_BIT_WDOG] & periph_div_en);
   assign want_run[1] = ~peripheral_standby_control_q[`PDMC_BIT_TMR16] &
      (periph_div_en | (stby_mode & tmr16_int_clk & subclk_tick));
   assign want_run[0] = ~peripheral_standby_control_q[`PDMC_BIT_TMR8] & periph_div_en;

   // glitch-free enables
   // Enables are flopped; the cell-level latch gate then only sees
   // changes while the gated clock is low, so no runt pulse escapes
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_gate
         always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               gate_q[gi] <= 1'b1;
            end else begin
               gate_q[gi] <= want_run[gi];
            end
         end
      end
   endgenerate

   assign serial_clk_en = gate_q[4];
   assign adc_clk_en = gate_q[3];
   assign wdog_clk_en = gate_q[2];
   assign tmr16_clk_en = gate_q[1];
   assign tmr8_clk_en = gate_q[0];

endmodule
`default_nettype wire

// file: tb/pdmc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module pdmc_chk (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic sleep_req,
   input wire logic irq_mask,
   input wire logic wdog_int_osc,
   input wire logic cpu_halt,
   input wire logic irq_handle,
   input wire logic osc_run,
   input wire logic port_hiz,
   input wire logic freq_apply,
   input wire logic serial_clk_en,
   input wire logic adc_clk_en,
   input wire logic wdog_clk_en,
   input wire logic tmr16_clk_en,
   input wire logic tmr8_clk_en,
   input wire logic serial_rst,
   input wire logic adc_rst,
   input wire logic tmr8_rst
);
   logic [7:0] sb_q;
   wire act = !cpu_halt;
   // Shadow of the standby register; enables lag it by one cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) sb_q <= 8'h00;
      else if (psel && penable && pwrite && paddr == 12'h000) sb_q <= pwdata[7:0];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_run;
      act && $past(act);
   endsequence
   a_serial_gate: assert property (s_run |-> serial_clk_en == !$past(sb_q[5]))
      else $error("serial clock enable wrong");
   a_adc_gate: assert property (s_run |-> adc_clk_en == !$past(sb_q[4]))
      else $error("adc clock enable wrong");
   a_wdog_gate: assert property (s_run ##0 $stable(wdog_int_osc) |->
      wdog_clk_en == !($past(sb_q[3]) && !wdog_int_osc)) else $error("wdog enable wrong");
   a_tmr16_gate: assert property (s_run |-> tmr16_clk_en == !$past(sb_q[2]))
      else $error("tmr16 clock enable wrong");
   a_tmr8_gate: assert property (s_run |-> tmr8_clk_en == !$past(sb_q[1]))
      else $error("tmr8 clock enable wrong");
   a_rsv_read_zero: assert property (psel && penable && !pwrite && paddr == 12'h000
      |-> prdata[31:6] == 26'h0 && !prdata[0]) else $error("reserved bits not zero");
   a_mask_blocks: assert property ($past(irq_mask) |-> !irq_handle)
      else $error("wake while masked");
   a_hiz_halted: assert property (port_hiz |-> cpu_halt)
      else $error("ports floated while running");
   a_deep_reset: assert property (!osc_run |-> tmr8_rst && serial_rst && adc_rst)
      else $error("modules not held in reset");
   a_freq_cause: assert property (freq_apply |-> $past(sleep_req))
      else $error("frequency applied without request");
endmodule
bind pdmc_top pdmc_chk i_chk (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sleep_req(sleep_req),
   .irq_mask(irq_mask), .wdog_int_osc(wdog_int_osc), .cpu_halt(cpu_halt),
   .irq_handle(irq_handle), .osc_run(osc_run), .port_hiz(port_hiz), .freq_apply(freq_apply),
   .serial_clk_en(serial_clk_en), .adc_clk_en(adc_clk_en), .wdog_clk_en(wdog_clk_en),
   .tmr16_clk_en(tmr16_clk_en), .tmr8_clk_en(tmr8_clk_en), .serial_rst(serial_rst),
   .adc_rst(adc_rst), .tmr8_rst(tmr8_rst));
`default_nettype wire

// file: tb/pdmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// CPU and interrupt controller stand-in
// ****************************************
module pdmc_cpu_model (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cpu_halt,
   input wire logic irq_handle,
   input wire logic do_sleep,
   input wire logic do_irq,
   output logic sleep_req,
   output logic irq_pending
);
   // Requests leave on the edge, like a real core
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_req <= 1'h0;
         irq_pending <= 1'h0;
      end else begin
         sleep_req <= do_sleep && !cpu_halt && !sleep_req;
         irq_pending <= (irq_pending || do_irq) && !irq_handle;
      end
   end
endmodule
`default_nettype wire

// file: tb/pdmc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
// ****************************************
// Bench
// ****************************************
module pdmc_tb_top;
   logic mclk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic irq_mask = 1'h0, direct_irq_en = 1'h0, ext_wake = 1'h0, wdog_int_osc = 1'h0;
   logic do_sleep = 1'h0, do_irq = 1'h0, tmr16_int_clk = 1'h0, subclk_tick = 1'h0;
   logic sleep_req, irq_pending, pready, pslverr, cpu_halt, cpu_reset, irq_handle;
   logic osc_run, port_hiz, port_hold, freq_apply;
   logic [31:0] prdata;
   logic [2:0] div, rs;
   logic [4:0] ck;
   int n_fail = 0, n_tests = 0;
   always #5 mclk = ~mclk;
   // Sixteen-bit timer clock sources are driven so the standby subclock path is seen
   pdmc_top i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .irq_pending(irq_pending),
      .irq_mask(irq_mask), .direct_irq_en(direct_irq_en), .ext_wake(ext_wake),
      .wdog_int_osc(wdog_int_osc), .tmr16_int_clk(tmr16_int_clk), .subclk_tick(subclk_tick),
      .cpu_halt(cpu_halt), .cpu_reset(cpu_reset), .irq_handle(irq_handle),
      .osc_run(osc_run), .port_hiz(port_hiz), .port_hold(port_hold),
      .freq_apply(freq_apply), .active_clock_divider(div), .periph_div_en(),
      .serial_clk_en(ck[4]), .adc_clk_en(ck[3]), .wdog_clk_en(ck[2]),
      .tmr16_clk_en(ck[1]), .tmr8_clk_en(ck[0]), .serial_rst(rs[2]), .adc_rst(rs[1]),
      .tmr8_rst(rs[0]));
   pdmc_cpu_model i_cpu (.mclk(mclk), .arst_n(arst_n), .cpu_halt(cpu_halt),
      .irq_handle(irq_handle), .do_sleep(do_sleep), .do_irq(do_irq),
      .sleep_req(sleep_req), .irq_pending(irq_pending));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One bus transfer; waits for pready, never assumes its timing
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int k;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'h1 && k < 50);
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      cyc(2);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'h1, a, d, r);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'h0, a, 32'h0, r);
      chk(nm, e, r);
      chk("pslverr", 32'h0, {31'h0, pslverr});
   endtask
   // Sleep instruction; reports whether a frequency change was seen
   task automatic slp(output logic f);
      f = 1'h0;
      do_sleep <= 1'h1;
      @(posedge mclk);
      do_sleep <= 1'h0;
      repeat (3) begin
         @(posedge mclk);
         @(negedge mclk);
         f = f | freq_apply;
      end
      @(posedge mclk);
   endtask
   task automatic irq;
      do_irq <= 1'h1;
      @(posedge mclk);
      do_irq <= 1'h0;
      cyc(6);
   endtask
   task automatic t_regs;
      rdc("stby", `PDMC_ADDR_STBY, 32'h0);
      rdc("mode", `PDMC_ADDR_STAT, 32'h1);
      wr(`PDMC_ADDR_STBY, 32'hFF);
      rdc("stby", `PDMC_ADDR_STBY, 32'h3E);
      chk("clk_en", 32'h0, {27'h0, ck});
      wdog_int_osc <= 1'h1;
      cyc(3);
      chk("wdog_en", 32'h1, {31'h0, ck[2]});
      wdog_int_osc <= 1'h0;
      wr(`PDMC_ADDR_STBY, 32'h14);
      chk("clk_en", 32'h15, {27'h0, ck});
      wr(`PDMC_ADDR_STBY, 32'h0);
      chk("clk_en", 32'h1F, {27'h0, ck});
      rdc("unmapped", 12'h010, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_sleep;
      logic f;
      wr(`PDMC_ADDR_SYS1, 32'h0);
      wr(`PDMC_ADDR_SYS2, 32'h0);
      irq_mask <= 1'h1;
      slp(f);
      rdc("mode", `PDMC_ADDR_STAT, 32'h2);
      chk("osc_clk", 32'h3F, {26'h0, osc_run, ck});
      irq();
      chk("halt", 32'h1, {31'h0, cpu_halt});
      irq_mask <= 1'h0;
      cyc(4);
      chk("halt", 32'h0, {31'h0, cpu_halt});
      slp(f);
      arst_n <= 1'h0;
      cyc(2);
      chk("reset", 32'h1, {31'h0, cpu_reset});
      arst_n <= 1'h1;
      cyc(2);
      rdc("mode", `PDMC_ADDR_STAT, 32'h1);
      $display("t_sleep done");
   endtask
   // Standby or subsleep, settle select 7 = 16 states, then wake
   task automatic t_deep(input logic [31:0] s1, input logic [31:0] s2,
                         input logic [31:0] st, input logic ew);
      logic f;
      int n;
      wr(`PDMC_ADDR_SYS1, s1);
      wr(`PDMC_ADDR_SYS2, s2);
      tmr16_int_clk <= !ew;
      subclk_tick <= !ew;
      slp(f);
      rdc("mode", `PDMC_ADDR_STAT, st);
      chk("tmr16_sub", {31'h0, !ew}, {31'h0, ck[1]});
      chk("osc_rst", 32'h7, {28'h0, osc_run, rs});
      chk("hiz", {31'h0, !ew}, {31'h0, port_hiz});
      if (ew) chk("hold", 32'h1, {31'h0, port_hold});
      n = 0;
      if (ew) ext_wake <= 1'h1;
      else do_irq <= 1'h1;
      do begin
         @(posedge mclk);
         ext_wake <= 1'h0;
         do_irq <= 1'h0;
         n++;
         @(negedge mclk);
      end while (irq_handle !== 1'h1 && n < 300);
      chk("settle", ew ? 32'h11 : 32'h12, n);
      @(posedge mclk);
      tmr16_int_clk <= 1'h0;
      subclk_tick <= 1'h0;
      $display("t_deep done");
   endtask
   task automatic t_direct;
      logic f;
      wr(`PDMC_ADDR_SYS1, 32'h0);
      wr(`PDMC_ADDR_SYS2, 32'h3C);
      direct_irq_en <= 1'h1;
      slp(f);
      chk("freq_div", 32'hF, {28'h0, f, div});
      chk("halt", 32'h0, {31'h0, cpu_halt});
      direct_irq_en <= 1'h0;
      slp(f);
      rdc("mode", `PDMC_ADDR_STAT, 32'h2);
      irq();
      chk("halt", 32'h0, {31'h0, cpu_halt});
      $display("t_direct done");
   endtask
   task automatic test_done;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(16);
      arst_n <= 1'h1;
      @(posedge mclk);
      t_regs();
      t_sleep();
      t_deep(32'hF0, 32'h0, 32'h8, 1'h0);
      t_deep(32'h70, 32'h80, 32'h4, 1'h1);
      t_direct();
      test_done();
   end
   // Whole run is under three hundred cycles; this cuts a hang short
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
